// >>> rtl/tmrm_regs.svh
// Register map constants for the temperature monitor register bank.
// Assumes inclusion by bare name from the design files.
`ifndef TMRM_REGS_SVH
`define TMRM_REGS_SVH
`define TMRM_PTR_LOC_HI_RD    8'h00
`define TMRM_PTR_REM_HI_RD    8'h01
`define TMRM_PTR_FLAGS_RD     8'h02
`define TMRM_PTR_SETUP_RD     8'h03
`define TMRM_PTR_RATE_RD      8'h04
`define TMRM_PTR_LUH_RD       8'h05
`define TMRM_PTR_LLH_RD       8'h06
`define TMRM_PTR_RUH_RD       8'h07
`define TMRM_PTR_RLH_RD       8'h08
`define TMRM_PTR_SETUP_WR     8'h09
`define TMRM_PTR_RATE_WR      8'h0a
`define TMRM_PTR_LUH_WR       8'h0b
`define TMRM_PTR_LLH_WR       8'h0c
`define TMRM_PTR_RUH_WR       8'h0d
`define TMRM_PTR_RLH_WR       8'h0e
`define TMRM_PTR_ONESHOT_WR   8'h0f
`define TMRM_PTR_REM_LO       8'h10
`define TMRM_PTR_RCORR_HI     8'h11
`define TMRM_PTR_RCORR_LO     8'h12
`define TMRM_PTR_RUL          8'h13
`define TMRM_PTR_RLL          8'h14
`define TMRM_PTR_LOC_LO       8'h15
`define TMRM_PTR_LUL          8'h16
`define TMRM_PTR_LLL          8'h17
`define TMRM_PTR_IDEAL        8'h18
`define TMRM_PTR_RCRIT        8'h19
`define TMRM_PTR_PREC         8'h1a
`define TMRM_PTR_LCRIT        8'h20
`define TMRM_PTR_HYST         8'h21
`define TMRM_PTR_FAULTCNT     8'h22
`define TMRM_PTR_LMIN_HI      8'h30
`define TMRM_PTR_SWRESET      8'hfc
`define TMRM_RST_ZERO         8'h00
`define TMRM_RST_UPPER        8'h55
`define TMRM_RST_RATE         8'h08
`define TMRM_RST_PREC         8'h1c
`define TMRM_RST_HYST         8'h0a
`define TMRM_RST_FAULTCNT     8'h81
`define TMRM_RST_LMIN_HI      8'hff
`define TMRM_MASK_NIBBLE      8'hf0
`define TMRM_MASK_SETUP       8'he4
`define TMRM_MASK_RATE        8'h0f
`define TMRM_MASK_PREC        8'h03
`define TMRM_MASK_FAULTCNT    8'h8e
`define TMRM_COH_NONE         2'h0
`define TMRM_COH_LOCAL        2'h1
`define TMRM_COH_REMOTE       2'h2
`endif

// >>> rtl/tmrm_pkg.sv
// Types shared by the temperature monitor register bank.
// Assumes tmrm_regs.svh is on the include path.
package tmrm_pkg;
  // One serial-side access: pointer load, data write or data read.
  typedef struct packed {
    logic       ptrWrite;
    logic       dataWrite;
    logic       dataRead;
    logic [7:0] wrData;
  } tmrm_access_t;

  // Two 12-bit conversion results delivered by the converter.
  typedef struct packed {
    logic        valid;
    logic [11:0] localBits;
    logic [11:0] remoteBits;
  } tmrm_result_t;

  typedef enum logic [1:0] {
    TMRM_IDLE,
    TMRM_AFTER_WRITE
  } tmrm_phase_t;
endpackage

// >>> rtl/tmrm_limit_pair.sv
// One 12-bit limit kept as a high byte and a low nibble.
// Assumes the caller decodes pointer values and passes write strobes.
`timescale 1ns/1ps
`default_nettype none
`include "tmrm_regs.svh"
module tmrm_limit_pair #(
  parameter logic [7:0] HIGH_RESET = 8'h00
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        softReset,
  input  wire logic        writeHigh,
  input  wire logic        writeLow,
  input  wire logic [7:0]  wrData,
  output logic      [11:0] bound
);
  logic [11:0] bound_reg;
  logic [11:0] bound_next;

  // Low writes keep only the nibble, so the lower bits always read zero.
  always_comb begin
    bound_next = bound_reg;
    if (softReset) begin
      bound_next = {HIGH_RESET, 4'h0};
    end else begin
      if (writeHigh) begin
        bound_next[11:4] = wrData;
      end
      if (writeLow) begin
        bound_next[3:0] = wrData[7:4];
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      bound_reg <= {HIGH_RESET, 4'h0};
    end else begin
      bound_reg <= bound_next;
    end
  end

  assign bound = bound_reg;
endmodule
`default_nettype wire

// >>> rtl/tmrm_register_bank.sv
// Register bank of a remote and local temperature monitor behind an 8-bit pointer.
// Assumes a serial front end that decodes the bus into one-cycle access strobes.
//
// Overview of operation
// - Local result bits 11..4 read at 00.
// - Local result low nibble read at 15.
// - Remote result bits 11..4 read at 01.
// - Remote result low nibble read at 10.
// - Local upper high: read 05, write 0B.
// - Local lower high: read 06, write 0C.
// - Remote upper high: read 07, write 0D.
// - Remote lower high: read 08, write 0E.
// - Remote limit low nibbles at 13, 14.
// - Local limit low nibbles at 16, 17.
// - Remote correction registers exist on one variant.
// - No write pointer read-only; no read pointer write-only.
// - Local minimum high at 30, resets FF.
// - Pointer loaded by each pointer write outside a software reset cycle, not by data writes; resets zero.
// - Low read follows high read's conversion.
// - Loading FC into the pointer restores power-on state.
`timescale 1ns/1ps
`default_nettype none
`include "tmrm_regs.svh"
module tmrm_register_bank #(
  parameter bit HAS_CORRECTION = 1'b1
) (
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  input  wire tmrm_pkg::tmrm_access_t access,
  input  wire tmrm_pkg::tmrm_result_t result,
  input  wire logic [7:0]            minimumUpdate,
  input  wire logic                  minimumLoad,
  input  wire logic [7:0]            stateFlags,
  output logic      [7:0]            rdData,
  output logic                       readValid,
  output logic      [7:0]            pointer,
  output logic                       oneShotStart,
  output logic                       softResetPulse,
  output logic      [11:0]           localUpperBound,
  output logic      [11:0]           localLowerBound,
  output logic      [11:0]           remoteUpperBound,
  output logic      [11:0]           remoteLowerBound,
  output logic      [11:0]           remoteCorrection,
  output logic      [7:0]            setupControl,
  output logic      [7:0]            samplingRate
);
  import tmrm_pkg::*;

  typedef struct packed {
    logic [7:0]  ptr;
    logic [11:0] localBits;
    logic [11:0] remoteBits;
    logic [3:0]  localLowHeld;
    logic [3:0]  remoteLowHeld;
    logic [1:0]  coherence;
    logic [7:0]  rdData;
    logic        readValid;
    logic        oneShot;
    logic        softReset;
    logic [7:0]  setup;
    logic [7:0]  rate;
    logic [11:0] correction;
    logic [7:0]  ideality;
    logic [7:0]  remoteCrit;
    logic [7:0]  precision;
    logic [7:0]  localCrit;
    logic [7:0]  hysteresis;
    logic [7:0]  faultCount;
    logic [7:0]  localMinHigh;
  } tmrm_state_t;

  tmrm_state_t state_reg;
  tmrm_state_t state_next;
  logic        dataWriteAt;
  logic        wrLuh;
  logic        wrLul;
  logic        wrLlh;
  logic        wrLll;
  logic        wrRuh;
  logic        wrRul;
  logic        wrRlh;
  logic        wrRll;

  // Power-on contents, shared by the asynchronous reset and the software reset.
  function automatic tmrm_state_t resetState();
    tmrm_state_t s;
    s              = '0;
    s.rate         = `TMRM_RST_RATE;
    s.precision    = `TMRM_RST_PREC;
    s.remoteCrit   = `TMRM_RST_UPPER;
    s.localCrit    = `TMRM_RST_UPPER;
    s.hysteresis   = `TMRM_RST_HYST;
    s.faultCount   = `TMRM_RST_FAULTCNT;
    s.localMinHigh = `TMRM_RST_LMIN_HI;
    return s;
  endfunction

  // A data write hits the register selected by the pointer at that moment.
  function automatic logic hit(input logic [7:0] ptrNow, input logic [7:0] target);
    return ptrNow == target;
  endfunction

  // Limit writes go to the write pointer values for the high bytes.
  assign dataWriteAt = access.dataWrite & ~state_reg.softReset;
  assign wrLuh = dataWriteAt & hit(state_reg.ptr, `TMRM_PTR_LUH_WR);
  assign wrLlh = dataWriteAt & hit(state_reg.ptr, `TMRM_PTR_LLH_WR);
  assign wrRuh = dataWriteAt & hit(state_reg.ptr, `TMRM_PTR_RUH_WR);
  assign wrRlh = dataWriteAt & hit(state_reg.ptr, `TMRM_PTR_RLH_WR);
  assign wrRul = dataWriteAt & hit(state_reg.ptr, `TMRM_PTR_RUL);
  assign wrRll = dataWriteAt & hit(state_reg.ptr, `TMRM_PTR_RLL);
  assign wrLul = dataWriteAt & hit(state_reg.ptr, `TMRM_PTR_LUL);
  assign wrLll = dataWriteAt & hit(state_reg.ptr, `TMRM_PTR_LLL);

  // The four limits share one storage module; low writes keep the nibble only.
  tmrm_limit_pair #(.HIGH_RESET(`TMRM_RST_UPPER)) localUpper (
    .clk       (clk),
    .arst_n    (arst_n),
    .softReset (state_reg.softReset),
    .writeHigh (wrLuh),
    .writeLow  (wrLul),
    .wrData    (access.wrData),
    .bound     (localUpperBound)
  );
  tmrm_limit_pair #(.HIGH_RESET(`TMRM_RST_ZERO)) localLower (
    .clk       (clk),
    .arst_n    (arst_n),
    .softReset (state_reg.softReset),
    .writeHigh (wrLlh),
    .writeLow  (wrLll),
    .wrData    (access.wrData),
    .bound     (localLowerBound)
  );
  tmrm_limit_pair #(.HIGH_RESET(`TMRM_RST_UPPER)) remoteUpper (
    .clk       (clk),
    .arst_n    (arst_n),
    .softReset (state_reg.softReset),
    .writeHigh (wrRuh),
    .writeLow  (wrRul),
    .wrData    (access.wrData),
    .bound     (remoteUpperBound)
  );
  tmrm_limit_pair #(.HIGH_RESET(`TMRM_RST_ZERO)) remoteLower (
    .clk       (clk),
    .arst_n    (arst_n),
    .softReset (state_reg.softReset),
    .writeHigh (wrRlh),
    .writeLow  (wrRll),
    .wrData    (access.wrData),
    .bound     (remoteLowerBound)
  );

  // Next-state logic: pointer load, data write, read mux and coherence hold.
  always_comb begin
    state_next           = state_reg;
    state_next.readValid = 1'b0;
    state_next.oneShot   = 1'b0;
    state_next.softReset = 1'b0;
    // Fresh results land here; a held low nibble shields a pending low read.
    if (result.valid) begin
      state_next.localBits  = result.localBits;
      state_next.remoteBits = result.remoteBits;
    end
    if (minimumLoad) begin
      state_next.localMinHigh = minimumUpdate;
    end
    if (state_reg.softReset) begin
      state_next = resetState();
    end else if (access.ptrWrite) begin
      state_next.ptr = access.wrData;
      if (access.wrData == `TMRM_PTR_SWRESET) begin
        state_next.softReset = 1'b1;
      end
    end else if (access.dataWrite) begin
      // Registers without a write pointer simply ignore the data.
      if (state_reg.ptr == `TMRM_PTR_SETUP_WR) begin
        state_next.setup = access.wrData & `TMRM_MASK_SETUP;
      end else if (state_reg.ptr == `TMRM_PTR_RATE_WR) begin
        state_next.rate = access.wrData & `TMRM_MASK_RATE;
      end else if (state_reg.ptr == `TMRM_PTR_ONESHOT_WR) begin
        state_next.oneShot = 1'b1;
      end else if (state_reg.ptr == `TMRM_PTR_RCORR_HI && HAS_CORRECTION) begin
        state_next.correction[11:4] = access.wrData;
      end else if (state_reg.ptr == `TMRM_PTR_RCORR_LO && HAS_CORRECTION) begin
        state_next.correction[3:0] = access.wrData[7:4];
      end else if (state_reg.ptr == `TMRM_PTR_IDEAL) begin
        state_next.ideality = access.wrData;
      end else if (state_reg.ptr == `TMRM_PTR_RCRIT) begin
        state_next.remoteCrit = access.wrData;
      end else if (state_reg.ptr == `TMRM_PTR_PREC) begin
        state_next.precision = `TMRM_RST_PREC | (access.wrData & `TMRM_MASK_PREC);
      end else if (state_reg.ptr == `TMRM_PTR_LCRIT) begin
        state_next.localCrit = access.wrData;
      end else if (state_reg.ptr == `TMRM_PTR_HYST) begin
        state_next.hysteresis = access.wrData;
      end else if (state_reg.ptr == `TMRM_PTR_FAULTCNT) begin
        state_next.faultCount = (access.wrData & `TMRM_MASK_FAULTCNT);
      end else if (state_reg.ptr == `TMRM_PTR_LMIN_HI) begin
        state_next.localMinHigh = access.wrData;
      end
    end else if (access.dataRead) begin
      state_next.readValid = 1'b1;
      state_next.coherence = `TMRM_COH_NONE;
      if (state_reg.ptr == `TMRM_PTR_LOC_HI_RD) begin
        state_next.rdData       = state_reg.localBits[11:4];
        state_next.localLowHeld = state_reg.localBits[3:0];
        state_next.coherence    = `TMRM_COH_LOCAL;
      end else if (state_reg.ptr == `TMRM_PTR_REM_HI_RD) begin
        state_next.rdData        = state_reg.remoteBits[11:4];
        state_next.remoteLowHeld = state_reg.remoteBits[3:0];
        state_next.coherence     = `TMRM_COH_REMOTE;
      end else if (state_reg.ptr == `TMRM_PTR_LOC_LO) begin
        state_next.rdData = {(state_reg.coherence == `TMRM_COH_LOCAL) ? state_reg.localLowHeld
                                                                     : state_reg.localBits[3:0],
                             4'h0};
      end else if (state_reg.ptr == `TMRM_PTR_REM_LO) begin
        state_next.rdData = {(state_reg.coherence == `TMRM_COH_REMOTE) ? state_reg.remoteLowHeld
                                                                      : state_reg.remoteBits[3:0],
                             4'h0};
      end else if (state_reg.ptr == `TMRM_PTR_FLAGS_RD) begin
        state_next.rdData = stateFlags;
      end else if (state_reg.ptr == `TMRM_PTR_SETUP_RD) begin
        state_next.rdData = state_reg.setup;
      end else if (state_reg.ptr == `TMRM_PTR_RATE_RD) begin
        state_next.rdData = state_reg.rate;
      end else if (state_reg.ptr == `TMRM_PTR_LUH_RD) begin
        state_next.rdData = localUpperBound[11:4];
      end else if (state_reg.ptr == `TMRM_PTR_LLH_RD) begin
        state_next.rdData = localLowerBound[11:4];
      end else if (state_reg.ptr == `TMRM_PTR_RUH_RD) begin
        state_next.rdData = remoteUpperBound[11:4];
      end else if (state_reg.ptr == `TMRM_PTR_RLH_RD) begin
        state_next.rdData = remoteLowerBound[11:4];
      end else if (state_reg.ptr == `TMRM_PTR_RUL) begin
        state_next.rdData = {remoteUpperBound[3:0], 4'h0};
      end else if (state_reg.ptr == `TMRM_PTR_RLL) begin
        state_next.rdData = {remoteLowerBound[3:0], 4'h0};
      end else if (state_reg.ptr == `TMRM_PTR_LUL) begin
        state_next.rdData = {localUpperBound[3:0], 4'h0};
      end else if (state_reg.ptr == `TMRM_PTR_LLL) begin
        state_next.rdData = {localLowerBound[3:0], 4'h0};
      end else if (state_reg.ptr == `TMRM_PTR_RCORR_HI && HAS_CORRECTION) begin
        state_next.rdData = state_reg.correction[11:4];
      end else if (state_reg.ptr == `TMRM_PTR_RCORR_LO && HAS_CORRECTION) begin
        state_next.rdData = {state_reg.correction[3:0], 4'h0};
      end else if (state_reg.ptr == `TMRM_PTR_IDEAL) begin
        state_next.rdData = state_reg.ideality;
      end else if (state_reg.ptr == `TMRM_PTR_RCRIT) begin
        state_next.rdData = state_reg.remoteCrit;
      end else if (state_reg.ptr == `TMRM_PTR_PREC) begin
        state_next.rdData = state_reg.precision;
      end else if (state_reg.ptr == `TMRM_PTR_LCRIT) begin
        state_next.rdData = state_reg.localCrit;
      end else if (state_reg.ptr == `TMRM_PTR_HYST) begin
        state_next.rdData = state_reg.hysteresis;
      end else if (state_reg.ptr == `TMRM_PTR_FAULTCNT) begin
        state_next.rdData = state_reg.faultCount;
      end else if (state_reg.ptr == `TMRM_PTR_LMIN_HI) begin
        state_next.rdData = state_reg.localMinHigh;
      end else begin
        // Write-only and unmapped pointers read as zero.
        state_next.rdData = `TMRM_RST_ZERO;
      end
    end
  end

  // Single register stage for all bank state apart from the four limits.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= resetState();
    end else begin
      state_reg <= state_next;
    end
  end

  assign rdData           = state_reg.rdData;
  assign readValid        = state_reg.readValid;
  assign pointer          = state_reg.ptr;
  assign oneShotStart     = state_reg.oneShot;
  assign softResetPulse   = state_reg.softReset;
  assign remoteCorrection = state_reg.correction;
  assign setupControl     = state_reg.setup;
  assign samplingRate     = state_reg.rate;

  // A pointer write lands in the pointer one cycle later.
  property pPtrLoad;
    @(posedge clk) disable iff (!arst_n)
      access.ptrWrite && !state_reg.softReset |=> pointer == $past(access.wrData);
  endproperty
  AST_PTR_LOAD: assert property (pPtrLoad) else $error("Pointer not loaded.");

  sequence sSwReset;
    access.ptrWrite && !state_reg.softReset && access.wrData == `TMRM_PTR_SWRESET;
  endsequence
  AST_SW_RESET: assert property (@(posedge clk) disable iff (!arst_n)
    sSwReset |=> softResetPulse ##1 (pointer == `TMRM_RST_ZERO && localUpperBound == {`TMRM_RST_UPPER, 4'h0}
      && samplingRate == `TMRM_RST_RATE)) else $error("Software reset incomplete.");

  AST_LOCAL_HIGH: assert property (@(posedge clk) disable iff (!arst_n)
    access.dataRead && !state_reg.softReset && pointer == `TMRM_PTR_LOC_HI_RD
    |=> readValid && rdData == $past(state_reg.localBits[11:4])) else $error("Local high wrong.");

  AST_REMOTE_HIGH: assert property (@(posedge clk) disable iff (!arst_n)
    access.dataRead && !state_reg.softReset && pointer == `TMRM_PTR_REM_HI_RD
    |=> rdData == $past(state_reg.remoteBits[11:4])) else $error("Remote high wrong.");

  AST_LOW_NIBBLE_ZERO: assert property (@(posedge clk) disable iff (!arst_n)
    access.dataRead && !state_reg.softReset && (pointer == `TMRM_PTR_LOC_LO || pointer == `TMRM_PTR_REM_LO)
    |=> rdData[3:0] == 4'h0) else $error("Low nibble not zero.");

  // Checker helper: the nibble seen by the latest local high read, kept apart from the bank state
  // so that the coherence check does not lean on the logic that it guards.
  logic       astPend_reg;
  logic [3:0] astNib_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      astPend_reg <= 1'b0;
      astNib_reg  <= 4'h0;
    end else if (state_reg.softReset) begin
      astPend_reg <= 1'b0;
    end else if (access.dataRead && !access.ptrWrite && !access.dataWrite) begin
      astPend_reg <= (pointer == `TMRM_PTR_LOC_HI_RD);
      if (pointer == `TMRM_PTR_LOC_HI_RD) begin
        astNib_reg <= state_reg.localBits[3:0];
      end
    end
  end

  // A low read that directly follows a local high read, pointer loads in between allowed.
  sequence sLocalLowRead;
    access.dataRead && !access.ptrWrite && !access.dataWrite && !state_reg.softReset
      && pointer == `TMRM_PTR_LOC_LO && astPend_reg;
  endsequence
  AST_COHERENT_LOW: assert property (@(posedge clk) disable iff (!arst_n)
    sLocalLowRead |=> rdData == {astNib_reg, 4'h0}) else $error("Low read incoherent.");

  AST_LUH_WRITE: assert property (@(posedge clk) disable iff (!arst_n)
    access.dataWrite && !state_reg.softReset && pointer == `TMRM_PTR_LUH_WR
    |=> localUpperBound[11:4] == $past(access.wrData)) else $error("Local upper not written.");

  AST_READ_ONLY_HIGH: assert property (@(posedge clk) disable iff (!arst_n)
    access.dataWrite && !state_reg.softReset && pointer == `TMRM_PTR_LUH_RD
    |=> $stable(localUpperBound)) else $error("Read pointer wrote limit.");

  AST_MIN_WRITE: assert property (@(posedge clk) disable iff (!arst_n)
    access.dataWrite && !access.ptrWrite && !state_reg.softReset && pointer == `TMRM_PTR_LMIN_HI
    |=> state_reg.localMinHigh == $past(access.wrData)) else $error("Minimum not written.");
endmodule
`default_nettype wire

// >>> verif/tmrm_host_model.sv
// Host side model: turns byte-level requests into one-cycle access strobes.
// Assumes the register bank takes a strobe on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module tmrm_host_model (
  input  wire logic                   clk,
  output var  tmrm_pkg::tmrm_access_t access,
  input  wire logic [7:0]             rdData,
  input  wire logic                   readValid
);
  import tmrm_pkg::*;

  // The data byte is parked on an inverted copy so that stale data never looks valid.
  initial begin
    access = '0;
  end

  // Kind 0 loads the pointer, 1 writes data, 2 reads data at the pointer.
  task automatic xfer(input int kind, input logic [7:0] d, output logic [7:0] q);
    q = 8'hxx;
    @(posedge clk);
    #1;
    access.ptrWrite  = (kind == 0);
    access.dataWrite = (kind == 1);
    access.dataRead  = (kind == 2);
    access.wrData    = d;
    @(posedge clk);
    #1;
    access.ptrWrite  = 1'b0;
    access.dataWrite = 1'b0;
    access.dataRead  = 1'b0;
    access.wrData    = ~d;
    if (kind == 2 && readValid === 1'b1) begin
      q = rdData;
    end
  endtask
endmodule
`default_nettype wire

// >>> verif/tb_top.sv
// Self-checking bench for the register bank, with a byte-array model of the map.
// Assumes the host model and the package are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import tmrm_pkg::*;
  logic         clk, arst_n, minimumLoad, readValid, oneShotStart, softResetPulse;
  logic [7:0]   minimumUpdate, stateFlags, rdData, pointer, setupControl, samplingRate, q, e;
  logic [11:0]  lub, llb, rub, rlb, rcorr, locBits, remBits;
  tmrm_access_t access;
  tmrm_result_t result;
  logic [7:0]   mdl [0:255];
  int           errTotal, totalChecks, cycles;
  // Read pointers whose contents are compared after reset, after the writes and after the software reset.
  logic [7:0]   rdList [0:24] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0f,
    8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1a, 8'h20, 8'h21, 8'h22, 8'h30};
  // Write pointer, matching read pointer and kept bits of each writable byte except precision.
  logic [7:0]   wrList [0:17] = '{8'h0b, 8'h0c, 8'h0d, 8'h0e, 8'h13, 8'h14, 8'h16, 8'h17, 8'h11, 8'h12, 8'h30,
    8'h09, 8'h0a, 8'h18, 8'h19, 8'h20, 8'h21, 8'h22};
  logic [7:0]   rbList [0:17] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h13, 8'h14, 8'h16, 8'h17, 8'h11, 8'h12, 8'h30,
    8'h03, 8'h04, 8'h18, 8'h19, 8'h20, 8'h21, 8'h22};
  logic [7:0]   mkList [0:17] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hf0, 8'hf0, 8'hf0, 8'hf0, 8'hff, 8'hf0, 8'hff,
    8'he4, 8'h0f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h8e};

  tmrm_register_bank #(.HAS_CORRECTION(1'b1)) dut (.clk(clk), .arst_n(arst_n), .access(access),
    .result(result), .minimumUpdate(minimumUpdate), .minimumLoad(minimumLoad), .stateFlags(stateFlags),
    .rdData(rdData), .readValid(readValid), .pointer(pointer), .oneShotStart(oneShotStart),
    .softResetPulse(softResetPulse), .localUpperBound(lub), .localLowerBound(llb), .remoteUpperBound(rub),
    .remoteLowerBound(rlb), .remoteCorrection(rcorr), .setupControl(setupControl), .samplingRate(samplingRate));
  tmrm_host_model host (.clk(clk), .access(access), .rdData(rdData), .readValid(readValid));

  // Free-running clock, 10 ns period.
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // A hang is cut short well above the roughly 560 cycles the run needs.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errTotal = errTotal + 1;
      endSim();
    end
  end

  task automatic endSim();
    if (errTotal == 0 && totalChecks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    totalChecks = totalChecks + 1;
    if (got !== exp) begin
      errTotal = errTotal + 1;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // The pointer is always aimed at the read address first, since some bytes read and write apart.
  task automatic rd(input logic [7:0] p, output logic [7:0] d);
    logic [7:0] dmy;
    host.xfer(0, p, dmy);
    host.xfer(2, 8'h00, d);
  endtask

  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    logic [7:0] dmy;
    host.xfer(0, p, dmy);
    host.xfer(1, d, dmy);
  endtask

  // Power-on contents of every modelled byte; unlisted or write-only places read zero.
  task automatic mdlReset();
    foreach (mdl[i]) mdl[i] = 8'h00;
    mdl[8'h04] = 8'h08;
    mdl[8'h05] = 8'h55;
    mdl[8'h07] = 8'h55;
    mdl[8'h19] = 8'h55;
    mdl[8'h1a] = 8'h1c;
    mdl[8'h20] = 8'h55;
    mdl[8'h21] = 8'h0a;
    mdl[8'h22] = 8'h81;
    mdl[8'h30] = 8'hff;
  endtask

  task automatic sweep();
    mdl[8'h02] = stateFlags;
    foreach (rdList[i]) begin
      rd(rdList[i], q);
      chk($sformatf("reg %h", rdList[i]), mdl[rdList[i]], q);
    end
  endtask

  // One conversion result; the model splits it into high byte and low nibble.
  task automatic convert(input logic [11:0] l, input logic [11:0] r);
    @(posedge clk);
    #1;
    result = {1'b1, l, r};
    @(posedge clk);
    #1;
    result.valid = 1'b0;
    locBits = l;
    remBits = r;
  endtask

  initial begin
    arst_n = 1'b0;
    result = '0;
    minimumUpdate = 8'h00;
    minimumLoad = 1'b0;
    errTotal = 0;
    totalChecks = 0;
    cycles = 0;
    locBits = 12'h000;
    remBits = 12'h000;
    void'($urandom(21991));
    stateFlags = 8'($urandom);
    repeat (10) @(posedge clk);
    #1;
    arst_n = 1'b1;
    mdlReset();
    chk("pointer", 8'h00, pointer);
    sweep();
    // Limits, correction, minimum and the other writable bytes written at their write addresses, then refused writes.
    foreach (wrList[i]) begin
      q = 8'($urandom);
      wr(wrList[i], q);
      mdl[rbList[i]] = q & mkList[i];
    end
    q = 8'($urandom);
    wr(8'h1a, q);
    mdl[8'h1a] = 8'h1c | (q & 8'h03);
    wr(8'h05, 8'($urandom));
    wr(8'h00, 8'($urandom));
    // The minimum tracker loads the local minimum high byte over the host's value.
    @(posedge clk);
    #1;
    minimumUpdate = 8'($urandom);
    minimumLoad = 1'b1;
    @(posedge clk);
    #1;
    minimumLoad = 1'b0;
    mdl[8'h30] = minimumUpdate;
    wr(8'h0f, 8'h5a);
    chk("oneShotStart", 8'h01, {7'h00, oneShotStart});
    sweep();
    chk("localUpperBound", mdl[8'h05], lub[11:4]);
    chk("localLowerBound", mdl[8'h06], llb[11:4]);
    chk("remoteUpperBound", mdl[8'h07], rub[11:4]);
    chk("remoteLowerBound", mdl[8'h08], rlb[11:4]);
    chk("remoteUpperBound low", mdl[8'h13], {rub[3:0], 4'h0});
    chk("remoteLowerBound low", mdl[8'h14], {rlb[3:0], 4'h0});
    chk("localUpperBound low", mdl[8'h16], {lub[3:0], 4'h0});
    chk("localLowerBound low", mdl[8'h17], {llb[3:0], 4'h0});
    chk("remoteCorrection", mdl[8'h11], rcorr[11:4]);
    chk("setupControl", mdl[8'h03], setupControl);
    chk("samplingRate", mdl[8'h04], samplingRate);
    // Results, then a low-byte read that must stay with the older conversion.
    for (int k = 0; k < 4; k++) begin
      convert(12'($urandom), 12'($urandom));
      rd(8'h00, q);
      chk("local high", locBits[11:4], q);
      rd(8'h15, q);
      chk("local low", {locBits[3:0], 4'h0}, q);
      rd(8'h01, q);
      chk("remote high", remBits[11:4], q);
      convert(12'($urandom), remBits);
      rd(8'h10, q);
      chk("remote low", {remBits[3:0], 4'h0}, q);
      rd(8'h00, q);
      chk("local high", locBits[11:4], q);
      e = {locBits[3:0], 4'h0};
      convert(12'($urandom), 12'($urandom));
      rd(8'h15, q);
      chk("held nibble", e, q);
      rd(8'h02, q);
      rd(8'h15, q);
      chk("fresh nibble", {locBits[3:0], 4'h0}, q);
    end
    // Software reset: loading the reset pointer value FC restores power-on contents.
    host.xfer(0, 8'hfc, q);
    chk("softResetPulse", 8'h01, {7'h00, softResetPulse});
    repeat (3) @(posedge clk);
    #1;
    mdlReset();
    chk("pointer", 8'h00, pointer);
    sweep();
    endSim();
  end
endmodule
`default_nettype wire
